/* src/ism_consts.svh */
// Offsets, field positions, reset values and codes of the input switch mapping block.
`ifndef ISM_CONSTS_SVH
`define ISM_CONSTS_SVH
// =====================================================================
// Register offsets (byte addresses on the plain register port).
`define ISM_ADDR_W 8
`define ISM_OFF_POLARITY 8'h36
`define ISM_OFF_KILL 8'h5D
`define ISM_OFF_FWD 8'h5F
`define ISM_OFF_REV 8'h60
// Per-pin function bytes, one per pin, at their own offsets.
`define ISM_OFF_FUNC_BUS_CLK 8'h3B
`define ISM_OFF_FUNC_BUS_DATA 8'h3C
`define ISM_OFF_FUNC_TX 8'h3D
`define ISM_OFF_FUNC_RX 8'h3E
`define ISM_OFF_FUNC_PULSE 8'h3F
// Live switch status, read only.
`define ISM_OFF_STATUS 8'h70
// =====================================================================
// Field layout.
`define ISM_NPINS 5
`define ISM_PIN_MASK 8'h1F
`define ISM_FUNC_LSB 0
`define ISM_FUNC_W 4
`define ISM_RESET_BYTE 8'h00
// Function codes that make a pin a switch.
`define ISM_FUNC_KILL 4'h7
`define ISM_FUNC_FWD 4'h8
`define ISM_FUNC_REV 4'h9
`endif

/* src/ism_pkg.sv */
// Types shared by the input switch mapping block.
package ism_pkg;
  // Pin index, bit order shared by every map byte.
  typedef enum logic [2:0] {
    ISM_PIN_BUS_CLK = 3'h0,
    ISM_PIN_BUS_DATA = 3'h1,
    ISM_PIN_TX = 3'h2,
    ISM_PIN_RX = 3'h3,
    ISM_PIN_PULSE = 3'h4
  } ism_pin_t;
  // Role of a pin as seen by this block.
  typedef enum logic [3:0] {
    ISM_ROLE_NONE = 4'b0001,
    ISM_ROLE_KILL = 4'b0010,
    ISM_ROLE_FWD = 4'b0100,
    ISM_ROLE_REV = 4'b1000
  } ism_role_t;
endpackage

/* src/ism_pin_sync.sv */
// Two-stage synchroniser for the five switch pins.
`timescale 1ns/1ps
`include "ism_consts.svh"
module ism_pin_sync (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Raw pins and synchronised copy.
  input wire logic [`ISM_NPINS-1:0] pins_async,
  output logic [`ISM_NPINS-1:0] pins_sync
);
  // =====================================================================
  // Synchroniser stages
  // First stage is read only by the second stage, to contain metastability.
  logic [`ISM_NPINS-1:0] stage1_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1_r <= '0;
      pins_sync <= '0;
    end else begin
      stage1_r <= pins_async;
      pins_sync <= stage1_r;
    end
  end
endmodule

/* src/ism_top.sv */
// Input switch mapping: polarity, role maps and switch status for five pins.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "ism_consts.svh"
module ism_top (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Register port.
  input wire logic [`ISM_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Switch pins, from outside the clock domain.
  input wire logic [`ISM_NPINS-1:0] switch_pins,
  // Switch status, registered.
  output logic kill_active,
  output logic fwd_limit_active,
  output logic rev_limit_active,
  output logic [`ISM_NPINS-1:0] pin_switch_active
);
  // =====================================================================
  // Storage
  logic [`ISM_NPINS-1:0] polarity_r; // Active-high select per pin.
  logic [`ISM_NPINS-1:0] kill_map_r; // Kill switch map.
  logic [`ISM_NPINS-1:0] fwd_map_r; // Forward limit map.
  logic [`ISM_NPINS-1:0] rev_map_r; // Reverse limit map.
  logic [`ISM_FUNC_W-1:0] func_r [`ISM_NPINS]; // Function field per pin.
  logic [`ISM_NPINS-1:0] pins_sync; // Synchronised pin levels.
  logic [`ISM_NPINS-1:0] active_nxt; // Polarity-corrected switch levels.
  logic [`ISM_NPINS-1:0] kill_nxt;
  logic [`ISM_NPINS-1:0] fwd_nxt;
  logic [`ISM_NPINS-1:0] rev_nxt;

  // Maps a function-byte offset to its pin, or 7 when no pin matches.
  function automatic logic [2:0] func_pin(input logic [`ISM_ADDR_W-1:0] a);
    case (a)
      `ISM_OFF_FUNC_BUS_CLK: func_pin = ism_pkg::ISM_PIN_BUS_CLK;
      `ISM_OFF_FUNC_BUS_DATA: func_pin = ism_pkg::ISM_PIN_BUS_DATA;
      `ISM_OFF_FUNC_TX: func_pin = ism_pkg::ISM_PIN_TX;
      `ISM_OFF_FUNC_RX: func_pin = ism_pkg::ISM_PIN_RX;
      `ISM_OFF_FUNC_PULSE: func_pin = ism_pkg::ISM_PIN_PULSE;
      default: func_pin = 3'h7;
    endcase
  endfunction

  // Decodes a function code into the switch role it selects.
  function automatic ism_pkg::ism_role_t role_of(input logic [`ISM_FUNC_W-1:0] f);
    case (f)
      `ISM_FUNC_KILL: role_of = ism_pkg::ISM_ROLE_KILL;
      `ISM_FUNC_FWD: role_of = ism_pkg::ISM_ROLE_FWD;
      `ISM_FUNC_REV: role_of = ism_pkg::ISM_ROLE_REV;
      default: role_of = ism_pkg::ISM_ROLE_NONE;
    endcase
  endfunction

  // =====================================================================
  // Pin synchroniser
  ism_pin_sync u_sync (
    .clk(clk),
    .rst(rst),
    .pins_async(switch_pins),
    .pins_sync(pins_sync)
  );

  // =====================================================================
  // Polarity register
  // Upper bits are not stored, so they read back as zero whatever is written.
  always_ff @(posedge clk) begin
    if (rst) begin
      polarity_r <= 5'(`ISM_RESET_BYTE);
    end else if (reg_wr && reg_addr == `ISM_OFF_POLARITY) begin
      polarity_r <= reg_wdata[`ISM_NPINS-1:0];
    end
  end

  // =====================================================================
  // Function fields and role maps
  // Writing a function byte also updates the three maps for that pin, so the
  // maps follow the functions without software keeping them in step.
  // A direct map write still wins for its own byte, for software that
  // loads the redundant bytes itself.
  always_ff @(posedge clk) begin
    if (rst) begin
      kill_map_r <= 5'(`ISM_RESET_BYTE);
      fwd_map_r <= 5'(`ISM_RESET_BYTE);
      rev_map_r <= 5'(`ISM_RESET_BYTE);
      for (int i = 0; i < `ISM_NPINS; i++) begin
        func_r[i] <= '0;
      end
    end else if (reg_wr) begin
      if (func_pin(reg_addr) != 3'h7) begin
        // Keep each map bit in agreement with the selected function.
        func_r[func_pin(reg_addr)] <= reg_wdata[`ISM_FUNC_W-1:0];
        kill_map_r[func_pin(reg_addr)] <=
          (role_of(reg_wdata[`ISM_FUNC_W-1:0]) == ism_pkg::ISM_ROLE_KILL);
        fwd_map_r[func_pin(reg_addr)] <=
          (role_of(reg_wdata[`ISM_FUNC_W-1:0]) == ism_pkg::ISM_ROLE_FWD);
        rev_map_r[func_pin(reg_addr)] <=
          (role_of(reg_wdata[`ISM_FUNC_W-1:0]) == ism_pkg::ISM_ROLE_REV);
      end else if (reg_addr == `ISM_OFF_KILL) begin
        kill_map_r <= reg_wdata[`ISM_NPINS-1:0];
      end else if (reg_addr == `ISM_OFF_FWD) begin
        fwd_map_r <= reg_wdata[`ISM_NPINS-1:0];
      end else if (reg_addr == `ISM_OFF_REV) begin
        rev_map_r <= reg_wdata[`ISM_NPINS-1:0];
      end
    end
  end

  // =====================================================================
  // Switch sensing
  // A pin counts as active only when mapped to a switch role; other uses of
  // the pin see the raw level, untouched by the polarity bit.
  always_comb begin
    for (int i = 0; i < `ISM_NPINS; i++) begin
      // Polarity 1 passes the level, polarity 0 inverts it.
      active_nxt[i] = (kill_map_r[i] | fwd_map_r[i] | rev_map_r[i]) &
                      (polarity_r[i] ? pins_sync[i] : ~pins_sync[i]);
    end
    kill_nxt = active_nxt & kill_map_r;
    fwd_nxt = active_nxt & fwd_map_r;
    rev_nxt = active_nxt & rev_map_r;
  end

  // =====================================================================
  // Status outputs
  // Registered so the outputs come straight from flip-flops; adds one cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      kill_active <= 1'b0;
      fwd_limit_active <= 1'b0;
      rev_limit_active <= 1'b0;
      pin_switch_active <= '0;
    end else begin
      kill_active <= |kill_nxt;
      fwd_limit_active <= |fwd_nxt;
      rev_limit_active <= |rev_nxt;
      pin_switch_active <= active_nxt;
    end
  end

  // =====================================================================
  // Read port
  // Data stand one cycle after the strobe and only then; zero otherwise.
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `ISM_OFF_POLARITY: reg_rdata <= {3'h0, polarity_r};
        `ISM_OFF_KILL: reg_rdata <= {3'h0, kill_map_r};
        `ISM_OFF_FWD: reg_rdata <= {3'h0, fwd_map_r};
        `ISM_OFF_REV: reg_rdata <= {3'h0, rev_map_r};
        `ISM_OFF_STATUS: reg_rdata <= {3'h0, active_nxt};
        `ISM_OFF_FUNC_BUS_CLK: reg_rdata <= {4'h0, func_r[0]};
        `ISM_OFF_FUNC_BUS_DATA: reg_rdata <= {4'h0, func_r[1]};
        `ISM_OFF_FUNC_TX: reg_rdata <= {4'h0, func_r[2]};
        `ISM_OFF_FUNC_RX: reg_rdata <= {4'h0, func_r[3]};
        `ISM_OFF_FUNC_PULSE: reg_rdata <= {4'h0, func_r[4]};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // =====================================================================
  // Assertions
  // A write to the polarity byte shows on read-back as its low five bits.
  sequence pol_write_s;
    reg_wr && reg_addr == `ISM_OFF_POLARITY;
  endsequence
  sequence pol_read_s;
    !reg_wr && reg_rd && reg_addr == `ISM_OFF_POLARITY;
  endsequence

  polarity_store_a: assert property (@(posedge clk) disable iff (rst)
    pol_write_s ##1 pol_read_s |=> reg_rdata == ($past(reg_wdata, 2) & `ISM_PIN_MASK))
    else $error("Polarity byte read-back differs from the written value.");

  unmapped_idle_a: assert property (@(posedge clk) disable iff (rst)
    !(kill_map_r[0] | fwd_map_r[0] | rev_map_r[0]) |=> !pin_switch_active[0])
    else $error("Pin shown active although it is not a switch.");

  active_low_a: assert property (@(posedge clk) disable iff (rst)
    kill_map_r[1] && !polarity_r[1] && !pins_sync[1] |=> kill_active)
    else $error("Low level with polarity clear did not raise kill.");

  active_high_a: assert property (@(posedge clk) disable iff (rst)
    fwd_map_r[2] && polarity_r[2] && pins_sync[2] |=> fwd_limit_active)
    else $error("High level with polarity set did not raise forward limit.");

  kill_map_a: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == `ISM_OFF_KILL |=> kill_map_r == $past(reg_wdata[4:0]))
    else $error("Kill map did not take the written byte.");

  fwd_map_a: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == `ISM_OFF_FWD |=> fwd_map_r == $past(reg_wdata[4:0]))
    else $error("Forward map did not take the written byte.");

  rev_map_a: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == `ISM_OFF_REV |=> rev_map_r == $past(reg_wdata[4:0]))
    else $error("Reverse map did not take the written byte.");

  func_code_a: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == `ISM_OFF_FUNC_RX && reg_wdata[3:0] == 4'h8
    |=> fwd_map_r[3] && !kill_map_r[3] && !rev_map_r[3])
    else $error("Function code 8 did not select forward limit.");

  // The status checks rebuild the active level from the maps, the polarity
  // and the synchronised pins, so a slip in the sensing logic shows here too.
  status_or_a: assert property (@(posedge clk) disable iff (rst)
    ##1 rev_limit_active == $past(|(rev_map_r & ~(polarity_r ^ pins_sync))))
    else $error("Reverse status is not the OR of mapped active pins.");

  kill_or_a: assert property (@(posedge clk) disable iff (rst)
    ##1 kill_active == $past(|(kill_map_r & ~(polarity_r ^ pins_sync))))
    else $error("Kill status is not the OR of mapped active pins.");

  fwd_or_a: assert property (@(posedge clk) disable iff (rst)
    ##1 fwd_limit_active == $past(|(fwd_map_r & ~(polarity_r ^ pins_sync))))
    else $error("Forward status is not the OR of mapped active pins.");

  // Reset leaves every status output low, whatever the pins show.
  // No disable here: this one must be watched while reset is applied.
  reset_quiet_a: assert property (@(posedge clk)
    rst |=> !kill_active && !fwd_limit_active && !rev_limit_active &&
    pin_switch_active == 5'h00)
    else $error("Status outputs not cleared by reset.");

  // Read data stand only in the cycle after a read strobe, so a stale byte
  // cannot be mistaken for a fresh read.
  read_idle_a: assert property (@(posedge clk) disable iff (rst)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("Read data present without a read strobe.");

  // With no pin mapped to any role, no pin may show active, whatever the
  // polarity byte holds.
  none_mapped_a: assert property (@(posedge clk) disable iff (rst)
    (kill_map_r | fwd_map_r | rev_map_r) == 5'h00 |=> pin_switch_active == 5'h00)
    else $error("Pin shown active although no pin is a switch.");

  // Function byte writes to one pin each: two pick one role, one picks none, one takes any code.
  sequence pulse_kill_code_s;
    reg_wr && reg_addr == `ISM_OFF_FUNC_PULSE && reg_wdata[3:0] == `ISM_FUNC_KILL;
  endsequence
  sequence clk_rev_code_s;
    reg_wr && reg_addr == `ISM_OFF_FUNC_BUS_CLK && reg_wdata[3:0] == `ISM_FUNC_REV;
  endsequence
  // A code below the kill code is no switch role at all.
  sequence tx_plain_code_s;
    reg_wr && reg_addr == `ISM_OFF_FUNC_TX && reg_wdata[3:0] < `ISM_FUNC_KILL;
  endsequence
  sequence rx_func_write_s;
    reg_wr && reg_addr == `ISM_OFF_FUNC_RX;
  endsequence

  pulse_kill_a: assert property (@(posedge clk) disable iff (rst)
    pulse_kill_code_s |=> kill_map_r[4] && !fwd_map_r[4] && !rev_map_r[4])
    else $error("Kill code on the pulse pin did not select kill only.");

  clk_rev_a: assert property (@(posedge clk) disable iff (rst)
    clk_rev_code_s |=> rev_map_r[0] && !kill_map_r[0] && !fwd_map_r[0])
    else $error("Reverse code on the bus clock pin did not select reverse only.");

  plain_code_a: assert property (@(posedge clk) disable iff (rst)
    tx_plain_code_s |=> !kill_map_r[2] && !fwd_map_r[2] && !rev_map_r[2])
    else $error("Non-switch code left a map bit set on the transmit pin.");

  // A function byte keeps only its low nibble, the field that picks the role.
  func_store_a: assert property (@(posedge clk) disable iff (rst)
    rx_func_write_s |=> func_r[3] == $past(reg_wdata[`ISM_FUNC_W-1:0]))
    else $error("Receive pin function field did not take the written code.");

  // A switch pin must be held for three cycles: two to cross the synchroniser
  // and one for the status flop. A shorter pulse may or may not be seen.
  sequence clk_pin_low_kill_s;
    (kill_map_r[0] && !polarity_r[0] && !switch_pins[0]) [*3];
  endsequence
  sequence rx_pin_high_rev_s;
    (rev_map_r[3] && polarity_r[3] && switch_pins[3]) [*3];
  endsequence

  low_to_kill_a: assert property (@(posedge clk) disable iff (rst)
    clk_pin_low_kill_s |=> kill_active && pin_switch_active[0])
    else $error("Held low kill pin did not reach the kill status.");

  high_to_rev_a: assert property (@(posedge clk) disable iff (rst)
    rx_pin_high_rev_s |=> rev_limit_active && pin_switch_active[3])
    else $error("Held high reverse pin did not reach the reverse status.");
endmodule

/* sim/ism_switch_model.sv */
// Behavioural model of the five external switches wired to the input pins.
`timescale 1ns/1ps
// =====================================================================
// Switch bank.
module ism_switch_model (
  // Contact levels commanded by the bench.
  input wire logic [4:0] level_cmd,
  // Pin levels seen by the block.
  output logic [4:0] pins
);
  // Each switch drives its pin hard, so there is no released level to model.
  assign pins = level_cmd;
endmodule

/* sim/ism_top_tb_top.sv */
// Self-checking bench for the input switch mapping block.
`timescale 1ns/1ps
`include "ism_consts.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
// =====================================================================
// Bench top.
module ism_top_tb_top;
  logic clk = 1'b0; // System clock.
  logic rst = 1'b1; // Synchronous reset.
  logic [7:0] reg_addr = 8'h00; // Register address.
  logic [7:0] reg_wdata = 8'h00; // Write data.
  logic reg_wr = 1'b0; // Write strobe.
  logic reg_rd = 1'b0; // Read strobe.
  logic [7:0] reg_rdata; // Read data.
  logic [4:0] lv = 5'h1F; // Commanded switch levels.
  logic [4:0] pins; // Pin levels.
  logic [4:0] act; // Per-pin active flags.
  logic kill, fwd, rev; // Role status outputs.
  int fails = 0; // Mismatches.
  int tests_run = 0; // Comparisons made.
  int cyc = 0; // Cycle counter for the hang guard.
  always #5 clk = ~clk;
  ism_switch_model u_ism_switch_model (.level_cmd(lv), .pins(pins));
  ism_top u_ism_top (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .switch_pins(pins),
    .kill_active(kill), .fwd_limit_active(fwd), .rev_limit_active(rev),
    .pin_switch_active(act));
  // A stuck run costs far more cycles than all scenarios together.
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      fails++;
      end_sim();
    end
  end
  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One-cycle write; bits 7:5 are always given as zero by the callers.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // One-cycle read; data is taken in the single cycle where it stands.
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask
  // Reset values, read-back and an unmapped address.
  task automatic t_regs();
    logic [7:0] offs [4];
    offs = '{`ISM_OFF_POLARITY, `ISM_OFF_KILL, `ISM_OFF_FWD, `ISM_OFF_REV};
    for (int i = 0; i < 4; i++) begin
      chk_rd(offs[i], 8'h00);
      wr(offs[i], 8'h15);
      chk_rd(offs[i], 8'h15);
      wr(offs[i], 8'h0A);
      chk_rd(offs[i], 8'h0A);
      wr(offs[i], 8'h00);
    end
    chk_rd(8'h50, 8'h00);
  endtask
  // Each pin alone in one role, both polarities, both levels, others idle.
  task automatic t_role(input logic [7:0] off, input int role);
    logic [4:0] e;
    for (int i = 0; i < 5; i++) begin
      // The function byte is set first so that it and the map byte agree.
      wr(8'(`ISM_OFF_FUNC_BUS_CLK + i), 8'(`ISM_FUNC_KILL + role));
      for (int k = 0; k < 4; k++) begin
        wr(off, 8'(1 << i));
        wr(`ISM_OFF_POLARITY, 8'((k & 1) << i));
        @(posedge clk);
        lv <= {5{k[1]}};
        repeat (4) @(posedge clk);
        #1;
        e = (k[1] == k[0]) ? 5'(1 << i) : 5'h00;
        `CHK(act, e)
        `CHK({kill, fwd, rev}, (e != 5'h00) ? 3'(4 >> role) : 3'b000)
        chk_rd(`ISM_OFF_STATUS, {3'b000, e});
      end
      wr(8'(`ISM_OFF_FUNC_BUS_CLK + i), 8'h00);
    end
    wr(off, 8'h00);
    wr(`ISM_OFF_POLARITY, 8'h00);
  endtask
  // Function codes decide the map bits of their pin.
  task automatic t_func();
    logic [3:0] codes [4];
    logic [7:0] b;
    codes = '{`ISM_FUNC_KILL, `ISM_FUNC_FWD, `ISM_FUNC_REV, 4'h2};
    for (int p = 0; p < 5; p++) begin
      for (int c = 0; c < 4; c++) begin
        b = 8'(1 << p);
        wr(8'(`ISM_OFF_FUNC_BUS_CLK + p), {4'h0, codes[c]});
        chk_rd(8'(`ISM_OFF_FUNC_BUS_CLK + p), {4'h0, codes[c]});
        chk_rd(`ISM_OFF_KILL, (c == 0) ? b : 8'h00);
        chk_rd(`ISM_OFF_FWD, (c == 1) ? b : 8'h00);
        chk_rd(`ISM_OFF_REV, (c == 2) ? b : 8'h00);
      end
      wr(8'(`ISM_OFF_FUNC_BUS_CLK + p), 8'h00);
    end
  endtask
  // Polarity write and read with no idle cycle between them; unmapped pins stay idle.
  task automatic t_b2b();
    @(posedge clk);
    reg_addr <= `ISM_OFF_POLARITY;
    reg_wdata <= 8'h13;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, 8'h13)
    @(posedge clk);
    #1;
    `CHK(reg_rdata, 8'h00)
    `CHK(act, 5'h00)
    wr(`ISM_OFF_POLARITY, 8'h00);
  endtask
  // Reset in mid-run clears the stored bytes and the status outputs.
  task automatic t_reset();
    wr(`ISM_OFF_FUNC_RX, 8'(`ISM_FUNC_KILL));
    wr(`ISM_OFF_POLARITY, 8'h08);
    repeat (4) @(posedge clk);
    #1;
    `CHK({kill, act}, 6'h28)
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK({kill, fwd, rev, act}, 8'h00)
    chk_rd(`ISM_OFF_POLARITY, 8'h00);
    chk_rd(`ISM_OFF_KILL, 8'h00);
    chk_rd(`ISM_OFF_FUNC_RX, 8'h00);
  endtask
  // Main sequence.
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK({kill, fwd, rev, act}, 8'h00)
    t_regs();
    t_b2b();
    t_role(`ISM_OFF_KILL, 0);
    t_role(`ISM_OFF_FWD, 1);
    t_role(`ISM_OFF_REV, 2);
    t_func();
    t_reset();
    end_sim();
  end
endmodule
